// [shared/phs_consts.svh]
// Purpose: Timing counts for the pipeline hazard and stall control block.
// Assumes: All counts are in cycles of the single 100 MHz processor clock.
// Notes: Every count is seven bits wide to match the stall accumulator.
`ifndef PHS_CONSTS_SVH
`define PHS_CONSTS_SVH
`define PHS_CNT_W 7
`define PHS_BASE_D1 7'h03
`define PHS_BASE_D2 7'h01
`define PHS_IDX_D1 7'h01
`define PHS_PART_SRC 7'h02
`define PHS_MEM_D1 7'h04
`define PHS_MEM_D2 7'h02
`define PHS_WR_BUSY 7'h01
`define PHS_BR_TAKEN 7'h02
`define PHS_CBR_PAIR 7'h02
`define PHS_ICM_NONSEQ 7'h05
`define PHS_ICM_SEQ 7'h02
`define PHS_DCM 7'h02
`define PHS_DCM_BURST 7'h03
`define PHS_BURST_R1 7'h03
`define PHS_BURST_R2 7'h02
`define PHS_TLB_NONE 7'h0f
`define PHS_TLB_L1 7'h11
`define PHS_TLB_L2 7'h16
`define PHS_TLB_BOTH 7'h18
`define PHS_DATA_XDW 7'h02
`define PHS_OP_XDW 7'h01
`define PHS_PAGE_XLAT 7'h02
`endif

// [shared/phs_pkg.sv]
// Purpose: Types shared by the pipeline hazard and stall control block.
// Assumes: Nothing beyond the constants header.
// Notes: Register ids cover integer and floating-point registers in one space.
package phs_pkg;
  typedef logic [4:0] phs_reg_type;
  typedef logic [31:0] phs_addr_type;
  typedef enum logic [1:0] {
    PHS_SZ_BYTE = 2'h0,
    PHS_SZ_WORD = 2'h1,
    PHS_SZ_DWORD = 2'h2
  } phs_size_type;
  typedef enum logic [1:0] {
    PHS_ALT_IDLE = 2'h1,
    PHS_ALT_HELD = 2'h2
  } phs_alt_state_type;
endpackage

// [design/phs_stall_timer.sv]
// Purpose: Down-counter that holds the pipeline stalled for a loaded count.
// Assumes: A load only arrives while the counter is idle.
// Notes: A load of zero leaves the pipeline running.
`include "phs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module phs_stall_timer (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [`PHS_CNT_W-1:0] load_val,
  output logic busy
);
  import phs_pkg::*;
  logic [`PHS_CNT_W-1:0] count_q;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      count_q <= 7'h00;
    end else if (load) begin
      count_q <= load_val;
    end else if (count_q != 7'h00) begin
      count_q <= count_q - 7'h01;
    end
  end

  assign busy = (count_q != 7'h00);

  AST_TIMER_HOLDS: assert property (@(posedge ref_clk) disable iff (!reset_n)
    load && load_val == 7'h03 |=> busy [*3] ##1 !busy)
    else $error("Stall timer did not hold for the loaded count.");
endmodule
`default_nettype wire

// [design/phs_mem_dep.sv]
// Purpose: Flags a possible read-after-write dependency between two references.
// Assumes: Only the low twelve address bits are compared.
// Notes: Some flagged cases are false dependencies; that costs cycles, never data.
`timescale 1ns/1ps
`default_nettype none
module phs_mem_dep (
  input wire logic rd_valid,
  input wire logic [11:0] rd_addr,
  input wire phs_pkg::phs_size_type rd_size,
  input wire logic rd_cross,
  input wire logic wr_valid,
  input wire logic [11:0] wr_addr,
  input wire phs_pkg::phs_size_type wr_size,
  input wire logic wr_cross,
  output logic dep
);
  import phs_pkg::*;
  logic wide;
  logic hit;

  always_comb begin
    wide = (rd_size != PHS_SZ_BYTE) || (wr_size != PHS_SZ_BYTE);
    hit = rd_cross || wr_cross || (rd_addr == wr_addr) ||
          ((rd_addr[11:2] == wr_addr[11:2]) && wide);
    dep = rd_valid && wr_valid && hit;
  end
endmodule
`default_nettype wire

// [design/phs_hazard_ctl.sv]
// Purpose: Hazard detection, branch stream handling and stall timing for a
//   four-stage pipeline.
// Assumes: Each instruction is presented once with its operand, memory, branch
//   and miss descriptors; caches and translation report misses at issue time.
// Notes: Penalties of one instruction are summed, which ignores overlap.
`include "phs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Base written by previous: three stalls.
// - Base written two back: one stall.
// - Top-of-stack pointer updates never interlock.
// - No base or index stall after address-unit-halting writer.
// - Index from previous: one stall, older none.
// - Bypass forwards source operand without stall.
// - Wider source than partial write: two stalls.
// - Integer and float registers share interlock ids.
// - Memory dependency by crossing, address match, or same word when either side is wider than a byte.
// - Memory dependency on previous: four stalls.
// - Memory dependency two back: two stalls.
// - Write occupancy costs one stall in pattern.
// - Predict taken: unconditional, backward, not-equal, less-equal.
// - Hold alternate stream; redirect on misprediction.
// - Unconditional costs as predicted-taken conditional.
// - Back-to-back conditional branches: two stalls.
// - Instruction miss: two-cycle gap, five when fetch is non-sequential.
// - Data miss two, burst three, reads after.
// - Translation stall 15, 17, 22 or 24.
// - Data crossing doubleword adds two stalls.
// - Straddling opcode non-sequential adds one.
// - Page change or serialize adds two, none with an instruction miss.
module phs_hazard_ctl (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic instr_valid,
  output logic instr_ready,
  output logic stall,
  input wire logic au_halts,
  input wire logic dst_valid,
  input wire phs_pkg::phs_reg_type dst_reg,
  input wire phs_pkg::phs_size_type dst_size,
  input wire logic base_valid,
  input wire phs_pkg::phs_reg_type base_reg,
  input wire logic top_of_stack_addressing,
  input wire logic index_valid,
  input wire phs_pkg::phs_reg_type index_reg,
  input wire logic src_valid,
  input wire phs_pkg::phs_reg_type src_reg,
  input wire phs_pkg::phs_size_type src_size,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [11:0] mem_addr,
  input wire phs_pkg::phs_size_type mem_size,
  input wire logic mem_cross,
  input wire logic br_valid,
  input wire logic br_cond,
  input wire logic br_backward,
  input wire logic br_ne_le,
  input wire phs_pkg::phs_addr_type br_target,
  input wire phs_pkg::phs_addr_type br_seq,
  input wire logic ex_resolve,
  input wire logic ex_taken,
  output logic fetch_load,
  output phs_pkg::phs_addr_type fetch_addr,
  output logic predict_taken,
  input wire logic ic_miss,
  input wire logic fetch_nonseq,
  input wire logic op_straddle,
  input wire logic page_change,
  input wire logic serialize,
  input wire logic dc_miss,
  input wire logic dc_burst,
  input wire logic tlb_event,
  input wire logic tlb_l1_upd,
  input wire logic tlb_l2_upd
);
  import phs_pkg::*;

  logic acc;
  logic busy;
  logic [`PHS_CNT_W-1:0] pen_total;
  logic [`PHS_CNT_W-1:0] pen_base;
  logic [`PHS_CNT_W-1:0] pen_idx;
  logic [`PHS_CNT_W-1:0] pen_src;
  logic [`PHS_CNT_W-1:0] pen_mem;
  logic [`PHS_CNT_W-1:0] pen_br;
  logic [`PHS_CNT_W-1:0] pen_store;
  logic [`PHS_CNT_W-1:0] pen_tlb;
  logic dep1;
  logic dep2;
  logic pred;

  // History of the last accepted instructions; h1 is the previous one.
  logic h1_dv_q;
  phs_reg_type h1_dst_q;
  phs_size_type h1_dsz_q;
  logic h1_halt_q;
  logic h1_mw_q;
  logic [11:0] h1_ma_q;
  phs_size_type h1_ms_q;
  logic h1_mx_q;
  logic h1_mem_q;
  logic h1_burst_q;
  logic h1_cbr_q;
  logic h2_dv_q;
  phs_reg_type h2_dst_q;
  logic h2_halt_q;
  logic h2_mw_q;
  logic [11:0] h2_ma_q;
  phs_size_type h2_ms_q;
  logic h2_mx_q;
  logic h2_burst_q;
  logic h3_mw_q;

  phs_alt_state_type alt_state_q;
  phs_addr_type alt_addr_q;
  logic alt_pred_q;
  logic fetch_load_q;
  phs_addr_type fetch_addr_q;
  logic pred_q;

  assign acc = instr_valid && !busy;
  assign instr_ready = !busy;
  assign stall = busy;
  assign fetch_load = fetch_load_q;
  assign fetch_addr = fetch_addr_q;
  assign predict_taken = pred_q;

  phs_mem_dep u_dep1 (
    .rd_valid(mem_rd),
    .rd_addr(mem_addr),
    .rd_size(mem_size),
    .rd_cross(mem_cross),
    .wr_valid(h1_mw_q),
    .wr_addr(h1_ma_q),
    .wr_size(h1_ms_q),
    .wr_cross(h1_mx_q),
    .dep(dep1)
  );

  phs_mem_dep u_dep2 (
    .rd_valid(mem_rd),
    .rd_addr(mem_addr),
    .rd_size(mem_size),
    .rd_cross(mem_cross),
    .wr_valid(h2_mw_q),
    .wr_addr(h2_ma_q),
    .wr_size(h2_ms_q),
    .wr_cross(h2_mx_q),
    .dep(dep2)
  );

  // Register ids are compared without regard to integer or float kind.
  always_comb begin
    pen_base = 7'h00;
    if (base_valid && !top_of_stack_addressing) begin
      if (h1_dv_q && !h1_halt_q && h1_dst_q == base_reg) begin
        pen_base = `PHS_BASE_D1;
      end else if (h2_dv_q && !h2_halt_q && h2_dst_q == base_reg) begin
        pen_base = `PHS_BASE_D2;
      end
    end
    pen_idx = 7'h00;
    if (index_valid && h1_dv_q && !h1_halt_q && h1_dst_q == index_reg) begin
      pen_idx = `PHS_IDX_D1;
    end
    // The bypass covers a same-width source; only a wider read waits.
    pen_src = 7'h00;
    if (src_valid && h1_dv_q && h1_dst_q == src_reg && src_size > h1_dsz_q) begin
      pen_src = `PHS_PART_SRC;
    end
  end

  always_comb begin
    pen_mem = 7'h00;
    if (dep1) begin
      pen_mem = `PHS_MEM_D1;
    end else if (dep2) begin
      pen_mem = `PHS_MEM_D2;
    end else if (h3_mw_q && h1_mem_q && mem_rd) begin
      pen_mem = `PHS_WR_BUSY;
    end
    if (mem_rd && h1_burst_q) begin
      pen_mem = pen_mem + `PHS_BURST_R1;
    end else if (mem_rd && h2_burst_q) begin
      pen_mem = pen_mem + `PHS_BURST_R2;
    end
  end

  always_comb begin
    pred = !br_cond || br_backward || br_ne_le;
    pen_br = 7'h00;
    if (br_valid && pred) begin
      pen_br = `PHS_BR_TAKEN;
    end
    if (br_valid && br_cond && h1_cbr_q) begin
      pen_br = pen_br + `PHS_CBR_PAIR;
    end
  end

  always_comb begin
    pen_store = 7'h00;
    if (ic_miss) begin
      pen_store = fetch_nonseq ? `PHS_ICM_NONSEQ : `PHS_ICM_SEQ;
    end else if (page_change || serialize) begin
      pen_store = `PHS_PAGE_XLAT;
    end
    if (op_straddle && fetch_nonseq) begin
      pen_store = pen_store + `PHS_OP_XDW;
    end
    if ((mem_rd || mem_wr) && mem_cross) begin
      pen_store = pen_store + `PHS_DATA_XDW;
    end
    if (dc_miss) begin
      pen_store = pen_store + `PHS_DCM;
      if (dc_burst) begin
        pen_store = pen_store + `PHS_DCM_BURST;
      end
    end
  end

  always_comb begin
    pen_tlb = 7'h00;
    if (tlb_event) begin
      case ({tlb_l2_upd, tlb_l1_upd})
        2'h0: pen_tlb = `PHS_TLB_NONE;
        2'h1: pen_tlb = `PHS_TLB_L1;
        2'h2: pen_tlb = `PHS_TLB_L2;
        default: pen_tlb = `PHS_TLB_BOTH;
      endcase
    end
    pen_total = pen_base + pen_idx + pen_src + pen_mem + pen_br + pen_store + pen_tlb;
  end

  phs_stall_timer u_timer (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .load(acc),
    .load_val(pen_total),
    .busy(busy)
  );

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      h1_dv_q <= 1'b0;
      h1_dst_q <= 5'h00;
      h1_dsz_q <= PHS_SZ_BYTE;
      h1_halt_q <= 1'b0;
      h1_cbr_q <= 1'b0;
      h2_dv_q <= 1'b0;
      h2_dst_q <= 5'h00;
      h2_halt_q <= 1'b0;
    end else if (acc) begin
      h1_dv_q <= dst_valid;
      h1_dst_q <= dst_reg;
      h1_dsz_q <= dst_size;
      h1_halt_q <= au_halts;
      h1_cbr_q <= br_valid && br_cond;
      h2_dv_q <= h1_dv_q;
      h2_dst_q <= h1_dst_q;
      h2_halt_q <= h1_halt_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      h1_mw_q <= 1'b0;
      h1_ma_q <= 12'h000;
      h1_ms_q <= PHS_SZ_BYTE;
      h1_mx_q <= 1'b0;
      h1_mem_q <= 1'b0;
      h1_burst_q <= 1'b0;
      h2_mw_q <= 1'b0;
      h2_ma_q <= 12'h000;
      h2_ms_q <= PHS_SZ_BYTE;
      h2_mx_q <= 1'b0;
      h2_burst_q <= 1'b0;
      h3_mw_q <= 1'b0;
    end else if (acc) begin
      h1_mw_q <= mem_wr;
      h1_ma_q <= mem_addr;
      h1_ms_q <= mem_size;
      h1_mx_q <= mem_cross;
      h1_mem_q <= mem_rd || mem_wr;
      h1_burst_q <= dc_miss && dc_burst;
      h2_mw_q <= h1_mw_q;
      h2_ma_q <= h1_ma_q;
      h2_ms_q <= h1_ms_q;
      h2_mx_q <= h1_mx_q;
      h2_burst_q <= h1_burst_q;
      h3_mw_q <= h2_mw_q;
    end
  end

  // Only one alternate address is kept; a second conditional branch
  // replaces it, which is why back-to-back conditionals pay extra.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      alt_state_q <= PHS_ALT_IDLE;
      alt_addr_q <= 32'h0000_0000;
      alt_pred_q <= 1'b0;
    end else if (acc && br_valid && br_cond) begin
      alt_state_q <= PHS_ALT_HELD;
      alt_addr_q <= pred ? br_seq : br_target;
      alt_pred_q <= pred;
    end else if (ex_resolve) begin
      case (alt_state_q)
        PHS_ALT_HELD: alt_state_q <= PHS_ALT_IDLE;
        PHS_ALT_IDLE: alt_state_q <= PHS_ALT_IDLE;
        default: alt_state_q <= PHS_ALT_IDLE;
      endcase
    end
  end

  // A new branch decode wins the fetch port over a resolution that lands
  // in the same cycle; the resolution of the older branch is then stale.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      fetch_load_q <= 1'b0;
      fetch_addr_q <= 32'h0000_0000;
      pred_q <= 1'b0;
    end else if (acc && br_valid) begin
      fetch_load_q <= pred;
      fetch_addr_q <= pred ? br_target : br_seq;
      pred_q <= pred;
    end else if (ex_resolve && alt_state_q == PHS_ALT_HELD && ex_taken != alt_pred_q) begin
      fetch_load_q <= 1'b1;
      fetch_addr_q <= alt_addr_q;
      pred_q <= ex_taken;
    end else begin
      fetch_load_q <= 1'b0;
    end
  end

  sequence s_base_prev;
    acc && base_valid && !top_of_stack_addressing && h1_dv_q && !h1_halt_q && h1_dst_q == base_reg;
  endsequence

  AST_BASE_PREV: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_base_prev |-> pen_base == 7'h03)
    else $error("Base interlock on previous writer is not three cycles.");

  AST_BASE_TOS: assert property (@(posedge ref_clk) disable iff (!reset_n)
    top_of_stack_addressing |-> pen_base == 7'h00)
    else $error("Top-of-stack addressing caused a base interlock.");

  AST_HALT_FREE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    acc && h1_halt_q && !(h2_dv_q && !h2_halt_q) |-> pen_base == 7'h00 && pen_idx == 7'h00)
    else $error("Address-unit-halting writer caused a register stall.");

  AST_IDX_OLD: assert property (@(posedge ref_clk) disable iff (!reset_n)
    acc && index_valid && !(h1_dv_q && h1_dst_q == index_reg) |-> pen_idx == 7'h00)
    else $error("Index stall charged without a previous writer.");

  AST_MEM_PREV: assert property (@(posedge ref_clk) disable iff (!reset_n)
    acc && mem_rd && h1_mw_q && mem_addr == h1_ma_q && !h1_burst_q && !h2_burst_q |-> pen_mem == 7'h04)
    else $error("Memory dependency on previous writer is not four cycles.");

  sequence s_stall_taken;
    acc && pen_total == 7'h02;
  endsequence

  AST_STALL_LEN: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_stall_taken |=> stall ##1 stall ##1 !stall)
    else $error("Stall length differs from the accepted penalty.");

  AST_TLB_BOTH: assert property (@(posedge ref_clk) disable iff (!reset_n)
    tlb_event && tlb_l1_upd && tlb_l2_upd |-> pen_tlb == 7'h18)
    else $error("Translation stall with both updates is not 24 cycles.");

  AST_REDIRECT: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ex_resolve && alt_state_q == PHS_ALT_HELD && ex_taken != alt_pred_q && !(acc && br_valid)
    |=> fetch_load && fetch_addr == $past(alt_addr_q))
    else $error("Misprediction did not redirect to the alternate stream.");

  AST_ICM_NONSEQ: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ic_miss && fetch_nonseq && !op_straddle && !mem_cross && !dc_miss |-> pen_store == 7'h05)
    else $error("Non-sequential instruction miss is not five cycles.");
endmodule
`default_nettype wire

// [dv/phs_far_model.sv]
// Purpose: Far-side model of the instruction cache, data cache and translation unit.
// Assumes: The bench sets the event mask shortly after a clock edge, for one issue.
// Notes: Events are plain levels so every combination can be presented at issue.
`timescale 1ns/1ps
`default_nettype none
module phs_far_model (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [9:0] ev,
  input wire logic fetch_load,
  input wire phs_pkg::phs_addr_type fetch_addr,
  output logic ic_miss,
  output logic fetch_nonseq,
  output logic op_straddle,
  output logic page_change,
  output logic serialize,
  output logic dc_miss,
  output logic dc_burst,
  output logic tlb_event,
  output logic tlb_l1_upd,
  output logic tlb_l2_upd,
  output phs_pkg::phs_addr_type seen_addr,
  output logic [7:0] seen_cnt
);
  import phs_pkg::*;
  // Miss, page and alignment reports go out with the instruction they belong to.
  assign {tlb_l2_upd, tlb_l1_upd, tlb_event, dc_burst, dc_miss} = ev[9:5];
  assign {serialize, page_change, op_straddle, fetch_nonseq, ic_miss} = ev[4:0];
  // The cache takes every redirect; the bench reads back what arrived, since a
  // one-cycle load pulse is easy to miss from a task that is busy elsewhere.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      seen_addr <= 32'h00000000;
      seen_cnt <= 8'h00;
    end else if (fetch_load) begin
      seen_addr <= fetch_addr;
      seen_cnt <= seen_cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// Purpose: Self-checking bench for the hazard and stall control block.
// Assumes: Hazard history advances per accepted instruction, not per idle cycle.
// Notes: An idle cycle may follow a stall-free issue so valid never toggles twice at once.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import phs_pkg::*;
  logic ref_clk, reset_n, instr_valid, instr_ready, stall, au_halts;
  logic dst_valid, base_valid, top_of_stack_addressing, index_valid, src_valid;
  logic mem_rd, mem_wr, mem_cross, br_valid, br_cond, br_backward, br_ne_le;
  logic ex_resolve, ex_taken, fetch_load, predict_taken;
  logic ic_miss, fetch_nonseq, op_straddle, page_change, serialize;
  logic dc_miss, dc_burst, tlb_event, tlb_l1_upd, tlb_l2_upd;
  logic [11:0] mem_addr;
  logic [9:0] ev;
  logic [7:0] seen_cnt;
  phs_reg_type dst_reg, base_reg, index_reg, src_reg;
  phs_size_type dst_size, src_size, mem_size;
  phs_addr_type br_target, br_seq, fetch_addr, seen_addr;
  int errors, samples_checked, fl_n;
  logic [9:0] ev_tab [11] = '{10'h003, 10'h001, 10'h008, 10'h010, 10'h006, 10'h004,
    10'h020, 10'h080, 10'h180, 10'h280, 10'h380};
  int exp_tab [11] = '{5, 2, 2, 2, 1, 0, 2, 15, 17, 22, 24};

  phs_hazard_ctl phs_hazard_ctl_i (
    .ref_clk, .reset_n, .instr_valid, .instr_ready, .stall, .au_halts, .dst_valid, .dst_reg, .dst_size,
    .base_valid, .base_reg, .top_of_stack_addressing, .index_valid, .index_reg, .src_valid, .src_reg,
    .src_size, .mem_rd, .mem_wr, .mem_addr, .mem_size, .mem_cross, .br_valid, .br_cond, .br_backward,
    .br_ne_le, .br_target, .br_seq, .ex_resolve, .ex_taken, .fetch_load, .fetch_addr, .predict_taken,
    .ic_miss, .fetch_nonseq, .op_straddle, .page_change, .serialize, .dc_miss, .dc_burst, .tlb_event,
    .tlb_l1_upd, .tlb_l2_upd
  );
  phs_far_model phs_far_model_i (
    .ref_clk, .reset_n, .ev, .fetch_load, .fetch_addr, .ic_miss, .fetch_nonseq, .op_straddle,
    .page_change, .serialize, .dc_miss, .dc_burst, .tlb_event, .tlb_l1_upd, .tlb_l2_upd,
    .seen_addr, .seen_cnt
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic chk_fetch(input phs_addr_type a);
    chk("fetch_count", fl_n, {24'h000000, seen_cnt});
    chk("fetch_addr", a, seen_addr);
  endtask

  task automatic clr();
    {au_halts, dst_valid, base_valid, top_of_stack_addressing, index_valid, src_valid} = 6'h00;
    {mem_rd, mem_wr, mem_cross, br_valid, br_cond, br_backward, br_ne_le} = 7'h00;
    {dst_reg, base_reg, index_reg, src_reg, mem_addr, ev} = 42'h0;
    dst_size = PHS_SZ_BYTE;
    src_size = PHS_SZ_BYTE;
    mem_size = PHS_SZ_BYTE;
    br_target = 32'h00001000;
    br_seq = 32'h00000200;
  endtask

  // Issues one instruction and counts the stall cycles that follow its accept.
  task automatic go(input int exp);
    int n;
    n = 0;
    instr_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    instr_valid = 1'b0;
    clr();
    while (stall === 1'b1 && n < 100) begin
      chk("instr_ready", 1'b0, instr_ready);
      n++;
      @(posedge ref_clk);
      #1;
    end
    if (n == 0) begin
      @(posedge ref_clk);
      #1;
    end
    if (exp >= 0) chk("stall_cycles", exp, n);
  endtask

  task automatic flush();
    repeat (3) go(0);
  endtask

  task automatic wr(input phs_reg_type r, input phs_size_type s);
    dst_valid = 1'b1;
    dst_reg = r;
    dst_size = s;
  endtask

  task automatic mem(input logic rd, input logic w, input logic [11:0] a, input phs_size_type s);
    mem_rd = rd;
    mem_wr = w;
    mem_addr = a;
    mem_size = s;
  endtask

  task automatic br(input logic c, input logic b, input logic nl);
    br_valid = 1'b1;
    {br_cond, br_backward, br_ne_le} = {c, b, nl};
  endtask

  task automatic resolve(input logic t);
    ex_resolve = 1'b1;
    ex_taken = t;
    @(posedge ref_clk);
    #1;
    ex_resolve = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic t_reset();
    chk("stall", 1'b0, stall);
    chk("instr_ready", 1'b1, instr_ready);
    chk("fetch_load", 1'b0, fetch_load);
    chk("fetch_addr", 32'h00000000, fetch_addr);
    chk("predict_taken", 1'b0, predict_taken);
    wr(5'h05, PHS_SZ_DWORD);
    go(0);
    reset_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    base_valid = 1'b1;
    base_reg = 5'h05;
    go(0);
    $display("test reset done");
  endtask

  task automatic t_reg();
    wr(5'h05, PHS_SZ_DWORD);
    go(0);
    {base_valid, base_reg} = {1'b1, 5'h05};
    go(3);
    flush();
    wr(5'h05, PHS_SZ_DWORD);
    go(0);
    go(0);
    {base_valid, base_reg} = {1'b1, 5'h05};
    go(1);
    flush();
    wr(5'h05, PHS_SZ_DWORD);
    go(0);
    {base_valid, base_reg, top_of_stack_addressing} = {1'b1, 5'h05, 1'b1};
    go(0);
    flush();
    wr(5'h05, PHS_SZ_DWORD);
    au_halts = 1'b1;
    go(0);
    {base_valid, base_reg} = {1'b1, 5'h05};
    go(0);
    flush();
    wr(5'h06, PHS_SZ_DWORD);
    go(0);
    {index_valid, index_reg} = {1'b1, 5'h06};
    go(1);
    wr(5'h06, PHS_SZ_DWORD);
    go(0);
    go(0);
    {index_valid, index_reg} = {1'b1, 5'h06};
    go(0);
    wr(5'h07, PHS_SZ_DWORD);
    go(0);
    {src_valid, src_reg, src_size} = {1'b1, 5'h07, PHS_SZ_DWORD};
    go(0);
    wr(5'h1c, PHS_SZ_BYTE);
    go(0);
    {src_valid, src_reg, src_size} = {1'b1, 5'h1c, PHS_SZ_DWORD};
    go(2);
    $display("test registers done");
  endtask

  task automatic t_mem();
    flush();
    mem(1'b0, 1'b1, 12'h010, PHS_SZ_DWORD);
    go(0);
    mem(1'b1, 1'b0, 12'h010, PHS_SZ_DWORD);
    go(4);
    flush();
    mem(1'b0, 1'b1, 12'h010, PHS_SZ_DWORD);
    go(0);
    go(0);
    mem(1'b1, 1'b0, 12'h010, PHS_SZ_DWORD);
    go(2);
    flush();
    mem(1'b0, 1'b1, 12'h014, PHS_SZ_WORD);
    go(0);
    mem(1'b1, 1'b0, 12'h016, PHS_SZ_BYTE);
    go(4);
    flush();
    mem(1'b0, 1'b1, 12'h014, PHS_SZ_BYTE);
    go(0);
    mem(1'b1, 1'b0, 12'h015, PHS_SZ_BYTE);
    go(0);
    flush();
    mem(1'b0, 1'b1, 12'h014, PHS_SZ_BYTE);
    mem_cross = 1'b1;
    go(2);
    mem(1'b1, 1'b0, 12'h800, PHS_SZ_BYTE);
    go(4);
    flush();
    mem(1'b0, 1'b1, 12'h100, PHS_SZ_BYTE);
    go(0);
    go(0);
    mem(1'b0, 1'b1, 12'h200, PHS_SZ_BYTE);
    go(0);
    mem(1'b1, 1'b0, 12'h300, PHS_SZ_BYTE);
    go(1);
    $display("test memory done");
  endtask

  task automatic t_branch();
    flush();
    br(1'b0, 1'b0, 1'b0);
    go(2);
    fl_n++;
    chk_fetch(32'h00001000);
    br(1'b1, 1'b1, 1'b0);
    go(2);
    fl_n++;
    chk_fetch(32'h00001000);
    resolve(1'b0);
    fl_n++;
    chk_fetch(32'h00000200);
    chk("predict_taken", 1'b0, predict_taken);
    flush();
    br(1'b1, 1'b0, 1'b1);
    go(2);
    fl_n++;
    chk_fetch(32'h00001000);
    resolve(1'b1);
    chk_fetch(32'h00001000);
    flush();
    br(1'b1, 1'b0, 1'b0);
    br_target = 32'h00003000;
    go(0);
    chk_fetch(32'h00001000);
    resolve(1'b1);
    fl_n++;
    chk_fetch(32'h00003000);
    resolve(1'b0);
    chk_fetch(32'h00003000);
    flush();
    br(1'b1, 1'b0, 1'b0);
    go(0);
    br(1'b1, 1'b0, 1'b0);
    go(2);
    $display("test branches done");
  endtask

  task automatic t_store();
    for (int i = 0; i < 11; i++) begin
      ev = ev_tab[i];
      go(exp_tab[i]);
    end
    ev = 10'h060;
    go(5);
    mem(1'b1, 1'b0, 12'h040, PHS_SZ_BYTE);
    go(3);
    ev = 10'h060;
    go(5);
    go(0);
    mem(1'b1, 1'b0, 12'h040, PHS_SZ_BYTE);
    go(2);
    $display("test storage done");
  endtask

  // The span allows some thirty times the few hundred cycles the tests need.
  initial begin
    #100000;
    errors++;
    report_and_stop();
  end

  initial begin
    clr();
    {instr_valid, ex_resolve, ex_taken, reset_n} = 4'h0;
    repeat (20) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    t_reset();
    t_reg();
    t_mem();
    t_branch();
    t_store();
    report_and_stop();
  end
endmodule
`default_nettype wire
